// File: logic/cpu_sfr_host.sv
// CPU core end: forwards SFR writes and runs the two-step sequences
`timescale 1ns/1ps
module cpu_sfr_host
  import fail_safe_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  output logic            busy_out,
  output logic            wake_irq_out,
  sfr_link_if.cpu         link
);
  logic [7:0] second_data;
  logic [1:0] second_addr;
  logic [7:0] rd_mux;
  logic [7:0] first_data;
  logic [1:0] first_addr;
  logic       cmd_any;

  wire cmd_wr   = wr_in && (addr_in == HOST_CMD) && !busy_out;
  wire plain_wr = wr_in && !addr_in[2] && !busy_out;

  // Refresh, idle and power-down commands become two link writes in adjacent cycles; slow-down on and off are one write
  always_comb begin
    first_addr = ADDR_POWER_CTRL_REG;
    first_data = link.power_ctrl_reg;
    cmd_any    = cmd_wr;
    if (wdata_in[CMD_REFRESH]) begin
      first_addr = ADDR_WDCTL;
      first_data = 8'h01 << REFRESH_BIT;
    end else if (wdata_in[CMD_IDLE]) begin
      first_data = link.power_ctrl_reg | IDLE_ARM;
    end else if (wdata_in[CMD_PD]) begin
      first_data = link.power_ctrl_reg | PD_ARM;
    end else if (wdata_in[CMD_SLOW_ON]) begin
      first_data = link.power_ctrl_reg | SLOW_SET;
    end else if (wdata_in[CMD_SLOW_OFF]) begin
      first_data = link.power_ctrl_reg & SLOW_CLR_MASK;
    end else begin
      cmd_any = 1'b0;
    end
    second_addr = wdata_in[CMD_REFRESH] ? ADDR_INT_ENABLE_REG_ONE : ADDR_POWER_CTRL_REG;
    second_data = wdata_in[CMD_REFRESH] ? (link.int_enable_reg_one | (8'h01 << START_BIT)) :
                  wdata_in[CMD_IDLE] ? (link.power_ctrl_reg | IDLE_SET) :
                                       (link.power_ctrl_reg | PD_SET);
  end

  wire        two_step = cmd_any && (wdata_in[CMD_REFRESH] ||
                         wdata_in[CMD_IDLE] || wdata_in[CMD_PD]);
  wire [7:0]  status   = {3'h0, link.wake_irq, link.running, link.cause,
                          link.chip_reset, busy_out};

  assign rd_mux = (addr_in == {1'b0, ADDR_POWER_CTRL_REG})   ? link.power_ctrl_reg :
                  (addr_in == {1'b0, ADDR_INT_ENABLE_REG_ONE})   ? link.int_enable_reg_one :
                  (addr_in == {1'b0, ADDR_RELOAD}) ? link.reload :
                  (addr_in == {1'b0, ADDR_WDCTL})  ? {link.cause, 7'h00} :
                  (addr_in == HOST_STATUS)         ? status : 8'h00;

  logic [7:0] pend_data;
  logic [1:0] pend_addr;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.wr      <= 1'b0;
      link.addr    <= ADDR_POWER_CTRL_REG;
      link.wdata   <= 8'h00;
      busy_out     <= 1'b0;
      pend_data    <= 8'h00;
      pend_addr    <= ADDR_POWER_CTRL_REG;
      rdata_out    <= 8'h00;
      wake_irq_out <= 1'b0;
    end else begin
      wake_irq_out <= link.wake_irq;
      rdata_out    <= rd_in ? rd_mux : 8'h00;
      if (busy_out) begin
        link.wr    <= 1'b1;
        link.addr  <= pend_addr;
        link.wdata <= pend_data;
        busy_out   <= 1'b0;
      end else if (cmd_any) begin
        link.wr    <= 1'b1;
        link.addr  <= first_addr;
        link.wdata <= first_data;
        busy_out   <= two_step;
        pend_addr  <= second_addr;
        pend_data  <= second_data;
      end else begin
        link.wr    <= plain_wr;
        link.addr  <= addr_in[1:0];
        link.wdata <= wdata_in;
      end
    end
  end
endmodule : cpu_sfr_host

// File: logic/fail_safe_device.sv
// Watchdog, oscillator monitor and power modes: the device end
// Operation
// - Watchdog is a 15-bit up-counter, rate clk/12..clk/192
// - Count clock via divide-by-two and divide-by-16
// - Software sets only the upper seven counter bits
// - Start bit starts watchdog; software cannot stop it
// - Unrefreshed overflow raises an internal reset
// - Refresh copies reload value into upper seven bits
// - Refresh is refresh bit then start bit
// - Readable flag tells watchdog from external reset
// - Watchdog holds in idle and power-down
// - Slow main oscillator: RC clock and hold reset
// - Recovered oscillator: 1 ms more reset, restart
// - Monitor clocks power-on reset, same comparison
// - Power-down stops both oscillators; wake pins restart
// - Wake: outpace, 1 ms, then wake-up interrupt
// - Idle gates CPU clock, peripherals keep running
// - Idle ends on enabled interrupt or reset
// - Idle entry is 01H then 20H
// - Power-down entry 02H then 40H; reset or pin exits
// - Power-down keeps RAM and register contents
// - Slow-down divides clocks by 32, works with idle
// - Slow-down set by 10H, cleared by mask 0EFH
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fail_safe_device
  import fail_safe_pkg::*;
#(
  parameter int SETTLE_LEN = SETTLE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ext_reset_in,
  input  wire logic       main_osc_tick_in,
  input  wire logic       rc_osc_tick_in,
  input  wire logic       ext_irq0_wake_pin_n_in,
  input  wire logic       can_rx_wake_pin_n_in,
  input  wire logic       periph_irq_in,
  sfr_link_if.device      link,
  output logic            chip_reset_out,
  output logic            clk_sel_rc_out,
  output logic            osc_stop_out,
  output logic            cpu_clk_en_out,
  output logic            periph_clk_en_out
);
  typedef enum logic [2:0] {
    OSC_FAIL, OSC_SETTLE, OSC_RUN, OSC_STOP, OSC_WAKE, OSC_WSETTLE
  } osc_state_t;

  osc_state_t            osc_state;
  osc_state_t            next_osc_state;
  logic [15:0]           settle_cnt;
  logic                  main_fast;
  logic [WDOG_WIDTH-1:0] wdog_cnt;
  logic [2:0]            machine_cnt;
  logic                  pre2;
  logic [3:0]            pre16;
  logic [4:0]            slow_cnt;
  logic [3:0]            wdog_rst_cnt;
  logic                  arm_refresh;
  logic                  arm_idle;
  logic                  arm_pd;
  logic [7:0]            next_power_ctrl_reg;

  // Write decode
  wire wr_power_ctrl_reg   = link.wr && (link.addr == ADDR_POWER_CTRL_REG);
  wire wr_int_enable_reg_one   = link.wr && (link.addr == ADDR_INT_ENABLE_REG_ONE);
  wire wr_reload = link.wr && (link.addr == ADDR_RELOAD);
  wire wr_wdctl  = link.wr && (link.addr == ADDR_WDCTL);
  wire idle_now  = |(link.power_ctrl_reg & IDLE_SET);
  wire pd_now    = |(link.power_ctrl_reg & PD_SET);
  wire slow_now  = |(link.power_ctrl_reg & SLOW_SET);
  wire sys_rst   = link.chip_reset;

  // Sequence steps; the arm only lives until the next write
  wire refresh_go = wr_int_enable_reg_one && link.wdata[START_BIT] && arm_refresh;
  wire idle_go    = wr_power_ctrl_reg && |(link.wdata & IDLE_SET) && arm_idle;
  wire pd_go      = wr_power_ctrl_reg && |(link.wdata & PD_SET) && arm_pd;
  wire wake_pin   = !ext_irq0_wake_pin_n_in || !can_rx_wake_pin_n_in;
  wire wake_go    = pd_now && wake_pin && (osc_state == OSC_STOP);

  // Common clock divider: every 32nd cycle in slow-down
  wire sys_tick   = !slow_now || (slow_cnt == SLOW_LAST);
  wire mtick      = sys_tick && (machine_cnt == MACHINE_LAST);
  wire pre2_tick  = mtick && pre2;
  wire wdog_tick  = pre2_tick &&
                    (!link.reload[PRESCALE_BIT] || pre16 == PRE16_LAST);
  wire count_en   = link.running && !idle_now && !pd_now;
  wire overflow   = count_en && wdog_tick && (&wdog_cnt);
  wire osc_hold   = (osc_state == OSC_FAIL) || (osc_state == OSC_SETTLE);
  wire settle_end = (settle_cnt == 16'(SETTLE_LEN - 1));
  wire rc_clock   = osc_hold || (osc_state == OSC_WAKE) ||
                    (osc_state == OSC_WSETTLE);

  osc_rate_compare i_osc_rate_compare (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (osc_state == OSC_STOP),
    .main_tick_in  (main_osc_tick_in),
    .rc_tick_in    (rc_osc_tick_in),
    .main_fast_out (main_fast)
  );

  // Oscillator monitor: one comparison for power-on, fault and wake
  always_comb begin
    next_osc_state = osc_state;
    case (osc_state)
      OSC_FAIL:    if (main_fast) next_osc_state = OSC_SETTLE;
      OSC_SETTLE: begin
        if (!main_fast) next_osc_state = OSC_FAIL;
        else if (settle_end) next_osc_state = OSC_RUN;
      end
      OSC_RUN: begin
        if (!main_fast) next_osc_state = OSC_FAIL;
        else if (pd_go) next_osc_state = OSC_STOP;
      end
      OSC_STOP: begin
        if (ext_reset_in) next_osc_state = OSC_FAIL;
        else if (wake_go) next_osc_state = OSC_WAKE;
      end
      OSC_WAKE:    if (main_fast) next_osc_state = OSC_WSETTLE;
      OSC_WSETTLE: begin
        if (!main_fast) next_osc_state = OSC_WAKE;
        else if (settle_end) next_osc_state = OSC_RUN;
      end
      default:     next_osc_state = OSC_FAIL;
    endcase
  end

  // Power control: slow bit plus idle and power-down state bits
  always_comb begin
    next_power_ctrl_reg = link.power_ctrl_reg;
    if (wr_power_ctrl_reg) next_power_ctrl_reg = (link.wdata & SLOW_SET) |
                             (link.power_ctrl_reg & (IDLE_SET | PD_SET));
    if (periph_irq_in) next_power_ctrl_reg = next_power_ctrl_reg & ~IDLE_SET;
    if (wake_go) next_power_ctrl_reg = next_power_ctrl_reg & ~PD_SET;
    // Entry beats a coincident exit so a completed sequence is never lost
    if (idle_go) next_power_ctrl_reg = next_power_ctrl_reg | IDLE_SET;
    if (pd_go) next_power_ctrl_reg = next_power_ctrl_reg | PD_SET;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_state  <= OSC_FAIL;
      settle_cnt <= 16'h0000;
    end else begin
      osc_state  <= next_osc_state;
      settle_cnt <= (next_osc_state == osc_state) ? settle_cnt + 16'h0001
                                                  : 16'h0000;
    end
  end

  // Internal reset; the watchdog part is stretched to a few cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.chip_reset <= 1'b1;
      chip_reset_out  <= 1'b1;
      wdog_rst_cnt    <= 4'h0;
      link.cause      <= 1'b0;
    end else begin
      link.chip_reset <= ext_reset_in || osc_hold || (wdog_rst_cnt != 4'h0);
      chip_reset_out  <= ext_reset_in || osc_hold || (wdog_rst_cnt != 4'h0);
      wdog_rst_cnt    <= overflow ? WDOG_RST_LEN
                                  : wdog_rst_cnt - {3'h0, |wdog_rst_cnt};
      if (overflow) link.cause <= 1'b1;
      else if (ext_reset_in) link.cause <= 1'b0;
    end
  end

  // Register state; power-down leaves it untouched
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.power_ctrl_reg    <= POWER_CTRL_REG_RESET;
      link.int_enable_reg_one    <= REG_RESET;
      link.reload  <= REG_RESET;
      link.running <= 1'b0;
      arm_refresh  <= 1'b0;
      arm_idle     <= 1'b0;
      arm_pd       <= 1'b0;
    end else if (sys_rst) begin
      link.power_ctrl_reg    <= POWER_CTRL_REG_RESET;
      link.int_enable_reg_one    <= REG_RESET;
      link.reload  <= REG_RESET;
      link.running <= 1'b0;
      arm_refresh  <= 1'b0;
      arm_idle     <= 1'b0;
      arm_pd       <= 1'b0;
    end else begin
      link.power_ctrl_reg <= next_power_ctrl_reg;
      if (wr_reload) link.reload <= link.wdata;
      if (wr_int_enable_reg_one) begin
        link.int_enable_reg_one            <= link.wdata;
        link.int_enable_reg_one[START_BIT] <= link.wdata[START_BIT] || link.running;
      end
      if (wr_int_enable_reg_one && link.wdata[START_BIT]) link.running <= 1'b1;
      if (link.wr) begin
        arm_refresh <= wr_wdctl && link.wdata[REFRESH_BIT];
        arm_idle    <= wr_power_ctrl_reg && |(link.wdata & IDLE_ARM);
        arm_pd      <= wr_power_ctrl_reg && |(link.wdata & PD_ARM);
      end
    end
  end

  // Watchdog prescalers and counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_cnt    <= '0;
      machine_cnt <= 3'h0;
      pre2        <= 1'b0;
      pre16       <= 4'h0;
      slow_cnt    <= 5'h00;
    end else if (sys_rst) begin
      wdog_cnt    <= '0;
      machine_cnt <= 3'h0;
      pre2        <= 1'b0;
      pre16       <= 4'h0;
      slow_cnt    <= 5'h00;
    end else begin
      slow_cnt <= slow_cnt + 5'h01;
      if (sys_tick)
        machine_cnt <= (machine_cnt == MACHINE_LAST) ? 3'h0
                                                     : machine_cnt + 3'h1;
      if (mtick) pre2 <= !pre2;
      if (pre2_tick) pre16 <= pre16 + 4'h1;
      if (refresh_go)
        wdog_cnt <= {link.reload[RELOAD_WIDTH-1:0], 8'h00};
      else if (count_en && wdog_tick)
        wdog_cnt <= wdog_cnt + 15'h0001;
    end
  end

  // Clock controls and the wake-up interrupt pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sel_rc_out    <= 1'b1;
      osc_stop_out      <= 1'b0;
      cpu_clk_en_out    <= 1'b0;
      periph_clk_en_out <= 1'b0;
      link.wake_irq     <= 1'b0;
    end else begin
      clk_sel_rc_out    <= rc_clock;
      osc_stop_out      <= (osc_state == OSC_STOP);
      cpu_clk_en_out    <= sys_tick && !idle_now && !pd_now;
      periph_clk_en_out <= sys_tick && !pd_now;
      link.wake_irq     <= (osc_state == OSC_WSETTLE) && main_fast &&
                           settle_end;
    end
  end
endmodule : fail_safe_device

// File: logic/fail_safe_pkg.sv
// Constants shared by the fail-safe device end and the CPU-side end
package fail_safe_pkg;
  // Special function register selects on the link
  localparam logic [1:0] ADDR_POWER_CTRL_REG     = 2'h0;
  localparam logic [1:0] ADDR_INT_ENABLE_REG_ONE     = 2'h1;
  localparam logic [1:0] ADDR_RELOAD   = 2'h2;
  localparam logic [1:0] ADDR_WDCTL    = 2'h3;
  // Bit positions and masks
  localparam int         START_BIT     = 6;
  localparam int         REFRESH_BIT   = 6;
  localparam int         PRESCALE_BIT  = 7;
  localparam logic [7:0] IDLE_ARM      = 8'h01;
  localparam logic [7:0] PD_ARM        = 8'h02;
  localparam logic [7:0] SLOW_SET      = 8'h10;
  localparam logic [7:0] IDLE_SET      = 8'h20;
  localparam logic [7:0] PD_SET        = 8'h40;
  localparam logic [7:0] SLOW_CLR_MASK = 8'hef;
  localparam logic [7:0] POWER_CTRL_REG_RESET    = 8'h00;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Watchdog geometry and prescalers
  localparam int         WDOG_WIDTH    = 15;
  localparam int         RELOAD_WIDTH  = 7;
  localparam logic [2:0] MACHINE_LAST  = 3'h5;
  localparam logic [3:0] PRE16_LAST    = 4'hf;
  localparam logic [4:0] SLOW_LAST     = 5'h1f;
  localparam logic [3:0] WDOG_RST_LEN  = 4'h8;
  // Oscillator comparison window, in RC oscillator ticks
  localparam logic [7:0] RC_WINDOW     = 8'h10;
  // Final settle phase after the main oscillator outpaces the RC one
  localparam int         SETTLE_US     = 1000;
  localparam int         CLK_MHZ       = 10;
  localparam int         SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // Host-side software map
  localparam logic [2:0] HOST_STATUS   = 3'h4;
  localparam logic [2:0] HOST_CMD      = 3'h5;
  localparam int         CMD_REFRESH   = 0;
  localparam int         CMD_IDLE      = 1;
  localparam int         CMD_PD        = 2;
  localparam int         CMD_SLOW_ON   = 3;
  localparam int         CMD_SLOW_OFF  = 4;
endpackage : fail_safe_pkg

// File: logic/osc_rate_compare.sv
// Compares main oscillator ticks against RC oscillator ticks per window
`timescale 1ns/1ps
module osc_rate_compare
  import fail_safe_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic clear_in,
  input  wire logic main_tick_in,
  input  wire logic rc_tick_in,
  output logic      main_fast_out
);
  logic [7:0] rc_cnt;
  logic [7:0] main_cnt;
  wire        window_end = rc_tick_in && (rc_cnt == RC_WINDOW - 8'h01);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rc_cnt        <= 8'h00;
      main_cnt      <= 8'h00;
      main_fast_out <= 1'b0;
    end else if (clear_in || window_end) begin
      rc_cnt        <= 8'h00;
      main_cnt      <= 8'h00;
      main_fast_out <= !clear_in && (main_cnt > RC_WINDOW);
    end else begin
      rc_cnt   <= rc_cnt + {7'h00, rc_tick_in};
      main_cnt <= (main_cnt == 8'hff) ? main_cnt
                                      : main_cnt + {7'h00, main_tick_in};
    end
  end
endmodule : osc_rate_compare

// File: logic/sfr_link_if.sv
// SFR link between the CPU core end and the fail-safe device end
`timescale 1ns/1ps
interface sfr_link_if;
  logic       wr;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] power_ctrl_reg;
  logic [7:0] int_enable_reg_one;
  logic [7:0] reload;
  logic       running;
  logic       cause;
  logic       chip_reset;
  logic       wake_irq;
  modport device (input wr, addr, wdata,
                  output power_ctrl_reg, int_enable_reg_one, reload, running, cause, chip_reset,
                  wake_irq);
  modport cpu    (output wr, addr, wdata,
                  input power_ctrl_reg, int_enable_reg_one, reload, running, cause, chip_reset,
                  wake_irq);
endinterface : sfr_link_if

// File: test/fail_safe_link_properties.sv
// Concurrent checks on the link between the CPU end and the device end
`timescale 1ns/1ps
module fail_safe_link_properties
  import fail_safe_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] power_ctrl_reg,
  input  wire logic [7:0] int_enable_reg_one,
  input  wire logic [7:0] reload,
  input  wire logic       running,
  input  wire logic       cause,
  input  wire logic       chip_reset,
  input  wire logic       wake_irq
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Writes landing while the internal reset holds are cleared, so skip them
  wire power_ctrl_reg_wr = wr && addr == ADDR_POWER_CTRL_REG && !chip_reset;
  sequence idle_arm;
    power_ctrl_reg_wr && wdata[0];
  endsequence
  sequence idle_go;
    power_ctrl_reg_wr && wdata[5];
  endsequence
  sequence pd_arm;
    power_ctrl_reg_wr && wdata[1];
  endsequence
  sequence pd_go;
    power_ctrl_reg_wr && wdata[6];
  endsequence
  sequence refresh_arm;
    wr && addr == ADDR_WDCTL && wdata[REFRESH_BIT];
  endsequence
  a_refresh_pair:
    assert property (refresh_arm |=> wr && addr == ADDR_INT_ENABLE_REG_ONE
                     && wdata[START_BIT])
    else $error("refresh second step missing");
  a_idle_entry:
    assert property (idle_arm ##1 idle_go |=> power_ctrl_reg[5])
    else $error("idle entry not taken");
  a_pd_entry:
    assert property (pd_arm ##1 pd_go |=> power_ctrl_reg[6])
    else $error("power-down entry not taken");
  a_slow_set:
    assert property (power_ctrl_reg_wr && wdata[4] |=> power_ctrl_reg[4])
    else $error("slow-down bit not set");
  a_slow_clear:
    assert property (power_ctrl_reg_wr && !wdata[4] |=> !power_ctrl_reg[4])
    else $error("slow-down bit not cleared");
  a_reload_copy:
    assert property (wr && addr == ADDR_RELOAD && !chip_reset
                     |=> reload == $past(wdata))
    else $error("reload register not written");
  a_start_sets:
    assert property (wr && addr == ADDR_INT_ENABLE_REG_ONE && wdata[START_BIT]
                     && !chip_reset |=> running)
    else $error("watchdog did not start");
  a_no_stop:
    assert property (running && !chip_reset |=> running || chip_reset)
    else $error("watchdog stopped without reset");
  a_cause_reset:
    assert property ($rose(cause) |-> ##[0:2] chip_reset)
    else $error("cause flag set without reset");
  a_wake_single:
    assert property (wake_irq |=> !wake_irq)
    else $error("wake-up pulse too long");
  a_reset_clears:
    assert property (chip_reset [*3] |-> power_ctrl_reg == POWER_CTRL_REG_RESET
                     && int_enable_reg_one == REG_RESET && !running)
    else $error("internal reset left state behind");
endmodule : fail_safe_link_properties

// File: test/tb_watchdog_osc_monitor_power_modes.sv
// Self-checking bench joining the device end and the CPU end
`timescale 1ns/1ps
module tb_watchdog_osc_monitor_power_modes
  import fail_safe_pkg::*;
;
  localparam int SETTLE = 20;
  localparam int LIMIT  = 60000;
  logic       clk_in;
  logic       rst_n_in;
  logic       ext_reset;
  logic       main_ok;
  logic       main_tick;
  logic       rc_tick;
  logic [1:0] rc_cnt;
  logic       wake0_n;
  logic       wake1_n;
  logic       irq;
  logic [2:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       wake_irq_out;
  logic       chip_reset_out;
  logic       clk_sel_rc_out;
  logic       osc_stop_out;
  logic       cpu_clk_en_out;
  logic       periph_clk_en_out;
  logic       cpu_en_b;
  int         n_errors;
  int         checks_done;
  int         cycles;
  sfr_link_if link ();
  sfr_link_if link_b ();
  fail_safe_device #(.SETTLE_LEN(SETTLE)) i_fail_safe_device (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_in(ext_reset),
    .main_osc_tick_in(main_tick), .rc_osc_tick_in(rc_tick),
    .ext_irq0_wake_pin_n_in(wake0_n), .can_rx_wake_pin_n_in(wake1_n),
    .periph_irq_in(irq), .link(link), .chip_reset_out(chip_reset_out),
    .clk_sel_rc_out(clk_sel_rc_out), .osc_stop_out(osc_stop_out),
    .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out));
  // Second device end driven straight by the bench to break the sequences
  fail_safe_device #(.SETTLE_LEN(SETTLE)) i_fail_safe_device_b (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_in(1'b0),
    .main_osc_tick_in(main_tick), .rc_osc_tick_in(rc_tick),
    .ext_irq0_wake_pin_n_in(1'b1), .can_rx_wake_pin_n_in(1'b1),
    .periph_irq_in(irq), .link(link_b), .chip_reset_out(),
    .clk_sel_rc_out(), .osc_stop_out(), .cpu_clk_en_out(cpu_en_b),
    .periph_clk_en_out());
  cpu_sfr_host i_cpu_sfr_host (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .busy_out(), .wake_irq_out(wake_irq_out),
    .link(link));
  fail_safe_link_properties i_fail_safe_link_properties (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wr(link.wr), .addr(link.addr),
    .wdata(link.wdata), .power_ctrl_reg(link.power_ctrl_reg), .int_enable_reg_one(link.int_enable_reg_one),
    .reload(link.reload), .running(link.running), .cause(link.cause),
    .chip_reset(link.chip_reset), .wake_irq(link.wake_irq));
  always #50 clk_in = ~clk_in;
  // Oscillators stand still in power-down, as the real ones would
  always @(posedge clk_in) begin
    rc_cnt    <= rc_cnt + 2'h1;
    main_tick <= main_ok && !osc_stop_out;
    rc_tick   <= rc_cnt == 2'h3 && !osc_stop_out;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask : sfr_read
  // Leaves the strobe high so that writes can follow with no gap
  task automatic lb_put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    link_b.wr    <= 1'b1;
    link_b.addr  <= a;
    link_b.wdata <= d;
  endtask : lb_put
  task automatic wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (chip_reset_out !== lvl && n < lim) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_rst
  initial begin
    logic [7:0] d;
    int         n;
    clk_in = 1'b0; rst_n_in = 1'b0; ext_reset = 1'b0; main_ok = 1'b1;
    main_tick = 1'b0; rc_tick = 1'b0; rc_cnt = 2'h0; wake0_n = 1'b1;
    wake1_n = 1'b1; irq = 1'b0; addr_in = 3'h0; wdata_in = 8'h00;
    wr_in = 1'b0; rd_in = 1'b0; link_b.wr = 1'b0; link_b.addr = 2'h0;
    link_b.wdata = 8'h00; n_errors = 0; checks_done = 0; cycles = 0;
    repeat (10) @(posedge clk_in);
    #1;
    check({7'h0, chip_reset_out}, 8'h01);
    check({7'h0, clk_sel_rc_out}, 8'h01);
    rst_n_in <= 1'b1;
    wait_rst(1'b0, 400, n);
    check(8'(n >= SETTLE && n < 400), 8'h01);
    check({7'h0, clk_sel_rc_out}, 8'h00);
    sfr_read(HOST_STATUS, d);
    check(d, 8'h00);
    lb_put(ADDR_POWER_CTRL_REG, IDLE_ARM);
    lb_put(ADDR_INT_ENABLE_REG_ONE, 8'h00);
    lb_put(ADDR_POWER_CTRL_REG, IDLE_ARM | IDLE_SET);
    @(posedge clk_in);
    link_b.wr <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check({7'h0, cpu_en_b}, 8'h01);
    lb_put(ADDR_POWER_CTRL_REG, IDLE_ARM);
    lb_put(ADDR_POWER_CTRL_REG, IDLE_SET);
    @(posedge clk_in);
    link_b.wr <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check({7'h0, cpu_en_b}, 8'h00);
    sfr_write(HOST_CMD, 8'(1 << CMD_IDLE));
    repeat (4) @(posedge clk_in);
    sfr_read(ADDR_POWER_CTRL_REG, d);
    check(d & IDLE_SET, IDLE_SET);
    check({6'h0, cpu_clk_en_out, periph_clk_en_out}, 8'h01);
    irq <= 1'b1;
    repeat (2) @(posedge clk_in);
    irq <= 1'b0;
    sfr_read(ADDR_POWER_CTRL_REG, d);
    check(d & IDLE_SET, 8'h00);
    sfr_write(HOST_CMD, 8'(1 << CMD_SLOW_ON));
    repeat (4) @(posedge clk_in);
    n = 0;
    repeat (64) begin
      @(posedge clk_in);
      #1;
      n = n + int'(periph_clk_en_out);
    end
    check(8'(n), 8'h02);
    sfr_write(HOST_CMD, 8'(1 << CMD_SLOW_OFF));
    repeat (2) @(posedge clk_in);
    sfr_read(ADDR_POWER_CTRL_REG, d);
    check(d & SLOW_SET, 8'h00);
    for (int i = 0; i < 2; i++) begin
      sfr_write(ADDR_RELOAD, 8'h33);
      sfr_write(HOST_CMD, 8'(1 << CMD_PD));
      repeat (6) @(posedge clk_in);
      #1;
      check({5'h0, osc_stop_out, cpu_clk_en_out, periph_clk_en_out},
            8'h04);
      if (i == 0) wake0_n <= 1'b0;
      else wake1_n <= 1'b0;
      repeat (3) @(posedge clk_in);
      wake0_n <= 1'b1;
      wake1_n <= 1'b1;
      n = 0;
      while (wake_irq_out !== 1'b1 && n < 400) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      check(8'(n < 400 && n > SETTLE), 8'h01);
      check({7'h0, osc_stop_out}, 8'h00);
      sfr_read(ADDR_RELOAD, d);
      check(d, 8'h33);
    end
    // Status is read-only, so this write must leave it untouched
    sfr_write(HOST_STATUS, 8'hff);
    sfr_read(HOST_STATUS, d);
    check(d, 8'h00);
    sfr_write(ADDR_RELOAD, 8'hff);
    sfr_write(ADDR_INT_ENABLE_REG_ONE, 8'h40);
    sfr_write(ADDR_INT_ENABLE_REG_ONE, 8'h00);
    sfr_read(HOST_STATUS, d);
    check(d, 8'h08);
    sfr_write(HOST_CMD, 8'(1 << CMD_REFRESH));
    wait_rst(1'b1, 48000, n);
    check(8'(n == 48000), 8'h01);
    wait_rst(1'b1, 2000, n);
    check(8'(n < 2000), 8'h01);
    wait_rst(1'b0, 400, n);
    sfr_read(HOST_STATUS, d);
    check(d, 8'h04);
    sfr_write(ADDR_RELOAD, 8'h7f);
    sfr_write(ADDR_INT_ENABLE_REG_ONE, 8'h40);
    sfr_write(HOST_CMD, 8'(1 << CMD_REFRESH));
    wait_rst(1'b1, 2900, n);
    check(8'(n == 2900), 8'h01);
    wait_rst(1'b1, 400, n);
    check(8'(n < 400), 8'h01);
    wait_rst(1'b0, 400, n);
    ext_reset <= 1'b1;
    repeat (3) @(posedge clk_in);
    ext_reset <= 1'b0;
    repeat (2) @(posedge clk_in);
    wait_rst(1'b0, 400, n);
    sfr_read(HOST_STATUS, d);
    check(d, 8'h00);
    main_ok <= 1'b0;
    wait_rst(1'b1, 300, n);
    check({6'h0, chip_reset_out, clk_sel_rc_out}, 8'h03);
    main_ok <= 1'b1;
    wait_rst(1'b0, 400, n);
    check(8'(n >= SETTLE && n < 400), 8'h01);
    close_out();
  end
endmodule : tb_watchdog_osc_monitor_power_modes
